// ### core/rx_pin_mux.sv
// One receive-input multiplexer: routes a selected remappable pin or ground.
`default_nettype none
module rx_pin_mux #(
    parameter int PIN_COUNT = rx_pin_sel_pkg::PIN_COUNT
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Synchronised pins, index equals the selection code.
    input wire logic [PIN_COUNT-1:0] pin_sync,
    // Selection code in, routed level out.
    rx_route_if.mux route
);
    logic rx_q;
    logic rx_d;

    always_comb begin
        rx_d = 1'b0;
        if (route.code == rx_pin_sel_pkg::SEL_GROUND) begin
            rx_d = 1'b0;
        end else if (route.code <= rx_pin_sel_pkg::SEL_MAX_PIN) begin
            // Code 121 lands on pin 121, the highest one.
            rx_d = pin_sync[route.code];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_q <= 1'b0;
        end else begin
            rx_q <= rx_d;
        end
    end

    assign route.rx = rx_q;
endmodule
`default_nettype wire

// ### core/rx_pin_sel_pkg.sv
// Constants shared by the receive pin selection block.
`default_nettype none
package rx_pin_sel_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] UART1_SEL_OFFSET = 12'h000;
    localparam logic [11:0] UART2_SEL_OFFSET = 12'h004;
    localparam int SEL_W = 7;
    localparam int SEL_LSB = 0;
    localparam int REG_W = 16;
    localparam logic [6:0] SEL_RESET = 7'h00;
    localparam logic [6:0] SEL_GROUND = 7'h00;
    localparam logic [6:0] SEL_MAX_PIN = 7'h79;
    localparam int PIN_COUNT = 122;
    localparam int UART_COUNT = 2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

// ### core/rx_route_if.sv
// Carrier between the register file and one receive-input multiplexer.
`default_nettype none
interface rx_route_if;
    logic [6:0] code;
    logic rx;
    modport ctrl (output code, input rx);
    modport mux (input code, output rx);
endinterface
`default_nettype wire

// ### core/uart_rx_input_pin_select.sv
// Receive pin selection for two UARTs with an AHB-Lite register slave.
`default_nettype none
module uart_rx_input_pin_select #(
    parameter int PIN_COUNT = rx_pin_sel_pkg::PIN_COUNT
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Remappable pins, index n is pin n; index 0 is unused.
    input wire logic [PIN_COUNT-1:0] remappable_pin_n,
    // Routed receive inputs.
    output logic first_uart_receive_input,
    output logic second_uart_receive_input
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    // Every pin crosses into the core clock through two flops; only the second is read.
    // Both flops reset low, the same level that a grounded receive input shows.
    logic [PIN_COUNT-1:0] pin_meta_q;
    logic [PIN_COUNT-1:0] pin_meta_d;
    logic [PIN_COUNT-1:0] pin_sync_q;
    logic [PIN_COUNT-1:0] pin_sync_d;

    always_comb begin
        pin_meta_d = remappable_pin_n;
        pin_sync_d = pin_meta_q;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture.
    logic wr_pend_q;
    logic wr_pend_d;
    logic [11:0] wr_addr_q;
    logic [11:0] wr_addr_d;
    logic addr_valid;

    // The address phase is captured only while hready is high, so a stalled
    // bus keeps the pending write and its address until the stall ends. Both
    // NONSEQ and SEQ carry bit 1 of htrans set and start a transfer.
    assign addr_valid = hsel && hready && htrans[1];

    always_comb begin
        wr_pend_d = wr_pend_q;
        wr_addr_d = wr_addr_q;
        if (hready) begin
            wr_pend_d = addr_valid && hwrite;
            wr_addr_d = haddr;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode.
    logic wr_addr_is_sel1;
    logic wr_addr_is_sel2;
    logic addr_is_sel1;
    logic addr_is_sel2;
    logic wr_hit1;
    logic wr_hit2;
    logic rd_take;
    logic rd_hit1;
    logic rd_hit2;

    // Only word address bits take part; the byte lane bits are ignored.
    assign wr_addr_is_sel1 = wr_addr_q[11:2] == rx_pin_sel_pkg::UART1_SEL_OFFSET[11:2];
    assign wr_addr_is_sel2 = wr_addr_q[11:2] == rx_pin_sel_pkg::UART2_SEL_OFFSET[11:2];
    assign addr_is_sel1 = haddr[11:2] == rx_pin_sel_pkg::UART1_SEL_OFFSET[11:2];
    assign addr_is_sel2 = haddr[11:2] == rx_pin_sel_pkg::UART2_SEL_OFFSET[11:2];

    // A write lands in its data phase, so it decodes the address captured one
    // cycle before; a read decodes the live address phase.
    assign wr_hit1 = wr_pend_q && wr_addr_is_sel1;
    assign wr_hit2 = wr_pend_q && wr_addr_is_sel2;
    assign rd_take = hready && addr_valid && !hwrite;
    assign rd_hit1 = rd_take && addr_is_sel1;
    assign rd_hit2 = rd_take && addr_is_sel2;

    ////////////////////////////////////////////////////////////////////////////
    // Selection registers.
    logic [6:0] uart1_rx_pin_selection_q;
    logic [6:0] uart1_rx_pin_selection_d;
    logic [6:0] uart2_rx_pin_selection_q;
    logic [6:0] uart2_rx_pin_selection_d;

    always_comb begin
        uart1_rx_pin_selection_d = uart1_rx_pin_selection_q;
        uart2_rx_pin_selection_d = uart2_rx_pin_selection_q;
        // Only the low seven bits are stored; bits 31..7 are dropped.
        // Any seven-bit code is kept; the multiplexer grounds codes with no pin.
        if (wr_hit1) begin
            uart1_rx_pin_selection_d = hwdata[6:0];
        end
        if (wr_hit2) begin
            uart2_rx_pin_selection_d = hwdata[6:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            uart1_rx_pin_selection_q <= rx_pin_sel_pkg::SEL_RESET;
            uart2_rx_pin_selection_q <= rx_pin_sel_pkg::SEL_RESET;
        end else begin
            uart1_rx_pin_selection_q <= uart1_rx_pin_selection_d;
            uart2_rx_pin_selection_q <= uart2_rx_pin_selection_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, built from next values so a write just ahead is seen.
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] rd_field1;
    logic [31:0] rd_field2;

    // Unimplemented upper bits are zero-filled here and nowhere else.
    assign rd_field1 = {25'h0000000, uart1_rx_pin_selection_d};
    assign rd_field2 = {25'h0000000, uart2_rx_pin_selection_d};

    // Outside a read the data bus returns to zero while hready is high; a stall holds the last value.
    always_comb begin
        rdata_d = rdata_q;
        if (hready) begin
            rdata_d = 32'h0000_0000;
            if (rd_hit1) begin
                rdata_d = rd_field1;
            end
            if (rd_hit2) begin
                rdata_d = rd_field2;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign hrdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus response.
    // Every register is a flop that answers in one cycle, so the slave never
    // stretches a data phase and never signals an error, even for an unmapped
    // address.
    assign hreadyout = 1'b1;
    assign hresp = rx_pin_sel_pkg::HRESP_OKAY;

    ////////////////////////////////////////////////////////////////////////////
    // Receive-input multiplexers, one per UART.
    // A pin edge reaches a receive output after three rising edges: two
    // synchroniser flops and the output flop inside the multiplexer. A new
    // selection takes effect one edge after the write commits.
    logic [6:0] sel_code [rx_pin_sel_pkg::UART_COUNT];
    logic [rx_pin_sel_pkg::UART_COUNT-1:0] rx_out;

    assign sel_code[0] = uart1_rx_pin_selection_q;
    assign sel_code[1] = uart2_rx_pin_selection_q;

    for (genvar u = 0; u < rx_pin_sel_pkg::UART_COUNT; u++) begin : g_uart
        rx_route_if route ();
        assign route.code = sel_code[u];
        assign rx_out[u] = route.rx;
        rx_pin_mux #(
            .PIN_COUNT(PIN_COUNT)
        ) u_mux (
            .core_clk(core_clk),
            .rstn(rstn),
            .pin_sync(pin_sync_q),
            .route(route)
        );
    end

    assign first_uart_receive_input = rx_out[0];
    assign second_uart_receive_input = rx_out[1];
endmodule
`default_nettype wire

// ### dv/uart_rx_input_pin_select_sva.sv
// Checker for the receive pin selection block.
`default_nettype none
module uart_rx_input_pin_select_sva #(parameter int PIN_COUNT = rx_pin_sel_pkg::PIN_COUNT) (
    input wire logic core_clk, rstn, hsel, hwrite, hready,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [31:0] hwdata, hrdata,
    input wire logic [PIN_COUNT-1:0] remappable_pin_n,
    input wire logic first_uart_receive_input, second_uart_receive_input
);
    logic ap, wr;
    logic [11:0] aa;
    logic [6:0] s1, s2;
    // Shadow copies of both selection fields, built from the bus traffic.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ap <= 1'b0; wr <= 1'b0; aa <= 12'h000; s1 <= 7'h00; s2 <= 7'h00;
        end else begin
            ap <= hsel && hready && htrans[1]; wr <= hwrite; aa <= haddr;
            if (ap && wr && aa[11:2] == 10'h000) s1 <= hwdata[6:0];
            if (ap && wr && aa[11:2] == 10'h001) s2 <= hwdata[6:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence hold_121;
        (s1 == 7'h79) [*4];
    endsequence
    AST_READ: assert property (ap && !wr |-> hrdata == (aa[11:2] == 10'h000 ? {25'h0, s1} :
        aa[11:2] == 10'h001 ? {25'h0, s2} : 32'h0)) else $error("read data wrong");
    AST_PIN121: assert property (hold_121 |->
        first_uart_receive_input == $past(remappable_pin_n[121], 3)) else $error("pin 121 lost");
    AST_GND1: assert property (s1 == 7'h00 |=> !first_uart_receive_input)
        else $error("first input not grounded");
    AST_UPPER: assert property (hrdata[31:7] == 25'h0)
        else $error("upper bits not zero");
    AST_GND2: assert property (s2 == 7'h00 |=> !second_uart_receive_input)
        else $error("second input not grounded");
    AST_RESET: assert property ($rose(rstn) |-> hrdata == 32'h0 && !first_uart_receive_input
        && !second_uart_receive_input) else $error("reset state wrong");
endmodule
`default_nettype wire

// ### dv/uart_rx_input_pin_select_tb.sv
// Testbench for the receive pin selection block.
`default_nettype none
module uart_rx_input_pin_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0, mk = 2'h0;
    logic [31:0] hwdata = 32'h0, exq[$];
    logic [121:0] pins = '0;
    logic [6:0] c1, c2;
    wire logic hready, frx, srx;
    wire logic [31:0] hrdata;
    int err_count = 0, cmp_count = 0;
    integer seed = 32'hE7A93730;
    always #10 core_clk = ~core_clk;
    uart_rx_input_pin_select dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(), .hrdata(hrdata), .remappable_pin_n(pins),
        .first_uart_receive_input(frx), .second_uart_receive_input(srx));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    always @(posedge core_clk) if (mk != 2'h0) chk(mk == 2'h1 ? "hrdata" : "rx",
        mk == 2'h1 ? hrdata : {30'h0, srx, frx}, exq.pop_front());
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, e);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
        @(posedge core_clk); while (!hready) @(posedge core_clk);
        htrans <= 2'h0; hwdata <= d;
        if (!w) begin exq.push_back(e); mk <= 2'h1; end
        @(posedge core_clk); while (!hready) @(posedge core_clk);
        mk <= 2'h0;
    endtask
    function automatic logic ex(input logic [6:0] c);
        return (c != 7'h00 && c <= 7'h79) ? pins[c] : 1'b0;
    endfunction
    task automatic rx(input logic [6:0] a, b);
        repeat (4) @(posedge core_clk);
        exq.push_back({30'h0, ex(b), ex(a)}); mk <= 2'h2;
        @(posedge core_clk);
        mk <= 2'h0;
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        pins <= '1;
        bus(1'b0, 12'h000, 32'h0, 32'h0);
        bus(1'b0, 12'h004, 32'h0, 32'h0);
        rx(7'h00, 7'h00);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            c1 = (i == 0) ? 7'h79 : 7'($random(seed));
            c2 = 7'($random(seed));
            pins <= 122'({$random(seed), $random(seed), $random(seed), $random(seed)});
            bus(1'b1, 12'h000, {25'h1FFFFFF, c1}, 32'h0);
            bus(1'b0, 12'h000, 32'h0, {25'h0, c1});
            bus(1'b1, 12'h004, {25'h1FFFFFF, c2}, 32'h0);
            bus(1'b0, 12'h004, 32'h0, {25'h0, c2});
            rx(c1, c2);
        end
        $display("routing test done");
        pins <= '1;
        bus(1'b1, 12'h000, 32'h0, 32'h0);
        bus(1'b1, 12'h004, 32'h0, 32'h0);
        rx(7'h00, 7'h00);
        bus(1'b1, 12'h008, 32'hFFFFFFFF, 32'h0);
        bus(1'b0, 12'h008, 32'h0, 32'h0);
        @(posedge core_clk);
        $display("ground and unmapped test done");
        conclude();
    end
    initial begin
        #200000;
        err_count++;
        conclude();
    end
endmodule
bind uart_rx_input_pin_select uart_rx_input_pin_select_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (
    .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .hwrite(hwrite), .hready(hready),
    .haddr(haddr), .htrans(htrans), .hwdata(hwdata), .hrdata(hrdata),
    .remappable_pin_n(remappable_pin_n), .first_uart_receive_input(first_uart_receive_input),
    .second_uart_receive_input(second_uart_receive_input));
`default_nettype wire
